// >>> common/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
    logic format_right;
    logic [9:0] value;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    logic [2:0] clock_sel;
    logic tick;

    modport formatter (
        input format_right,
        input value,
        output high_byte,
        output low_byte
    );

    modport ticker (
        input clock_sel,
        output tick
    );

    modport owner (
        output format_right,
        output value,
        output clock_sel,
        input high_byte,
        input low_byte,
        input tick
    );
endinterface : adc_link_if

// >>> common/adc_regs_map.svh
`ifndef ADC_REGS_MAP_SVH
`define ADC_REGS_MAP_SVH

// Register byte offsets on the register bus.
`define ADC_OFS_CONTROL 12'h000
`define ADC_OFS_RESULT_HIGH 12'h004
`define ADC_OFS_RESULT_LOW 12'h008
`define ADC_OFS_STATUS 12'h00C

// Field positions of the control register.
`define ADC_CTL_FORMAT_BIT 7
`define ADC_CTL_CLOCK_MSB 6
`define ADC_CTL_CLOCK_LSB 4
`define ADC_CTL_NEG_REF_BIT 2
`define ADC_CTL_POS_REF_MSB 1
`define ADC_CTL_POS_REF_LSB 0

// Field positions of the status register.
`define ADC_STS_FRESH_BIT 0
`define ADC_STS_POS_RSVD_BIT 1
`define ADC_STS_COUNT_MSB 15
`define ADC_STS_COUNT_LSB 8

// Reset values.
`define ADC_CONTROL_RESET 8'h00
`define ADC_COUNT_RESET 8'h00
`define ADC_RDATA_RESET 32'h0000_0000

// Positive reference code that is reserved.
`define ADC_POS_REF_RESERVED 2'h1

// System clock cycles per conversion clock tick for each divided code.
`define ADC_DIV_CODE0 7'h02
`define ADC_DIV_CODE1 7'h08
`define ADC_DIV_CODE2 7'h20
`define ADC_DIV_CODE4 7'h04
`define ADC_DIV_CODE5 7'h10
`define ADC_DIV_CODE6 7'h40

`endif

// >>> common/adc_regs_pkg.sv
package adc_regs_pkg;

    // Conversion clock select codes; both RC codes (3 and 7) pick the dedicated oscillator.
    typedef enum logic [2:0] {
        CLK_SYS_DIV2 = 3'h0,
        CLK_SYS_DIV8 = 3'h1,
        CLK_SYS_DIV32 = 3'h2,
        CLK_RC_OSC = 3'h3,
        CLK_SYS_DIV4 = 3'h4,
        CLK_SYS_DIV16 = 3'h5,
        CLK_SYS_DIV64 = 3'h6,
        CLK_RC_OSC_ALT = 3'h7
    } clock_select_type;

    typedef enum logic [4:0] {
        SEL_NONE = 5'h01,
        SEL_CONTROL = 5'h02,
        SEL_RESULT_HIGH = 5'h04,
        SEL_RESULT_LOW = 5'h08,
        SEL_STATUS = 5'h10
    } reg_select_type;

    typedef struct packed {
        logic format_right;
        logic [2:0] clock_sel;
        logic neg_ref;
        logic [1:0] pos_ref;
        logic [7:0] res_high;
        logic [7:0] res_low;
        logic result_fresh;
        logic [7:0] done_count;
        logic [31:0] rdata;
        logic slverr;
    } regs_state_type;

    typedef struct packed {
        logic [6:0] div_cnt;
        logic rc_sync1;
        logic rc_sync2;
        logic rc_prev;
        logic tick;
    } ticker_state_type;

endpackage : adc_regs_pkg

// >>> design/adc_config_and_result_regs.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "adc_regs_map.svh"
module adc_config_and_result_regs
    import adc_regs_pkg::*;
(
    // Clock and reset.
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    // APB slave.
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Converter core.
    input wire logic CONV_DONE_IN,
    input wire logic [9:0] CONV_VALUE_IN,
    // Dedicated RC oscillator.
    input wire logic RC_OSC_IN,
    // Configuration to the analog side.
    output logic CONV_TICK_OUT,
    output logic [2:0] CONV_CLOCK_SELECT_OUT,
    output logic RC_CLOCK_SELECTED_OUT,
    output logic [1:0] POS_REF_SELECT_OUT,
    output logic NEG_REF_SELECT_OUT,
    output logic FORMAT_RIGHT_OUT
);

    regs_state_type s_q;
    regs_state_type s_d;
    adc_link_if link ();

    logic setup_phase;
    logic write_done;
    logic [7:0] control_reset;
    reg_select_type sel;

    function automatic reg_select_type decode(input logic [11:0] addr);
        case (addr)
            `ADC_OFS_CONTROL: decode = SEL_CONTROL;
            `ADC_OFS_RESULT_HIGH: decode = SEL_RESULT_HIGH;
            `ADC_OFS_RESULT_LOW: decode = SEL_RESULT_LOW;
            `ADC_OFS_STATUS: decode = SEL_STATUS;
            default: decode = SEL_NONE;
        endcase
    endfunction : decode

    function automatic logic [7:0] control_byte(input regs_state_type s);
        control_byte = 8'h00;
        control_byte[`ADC_CTL_FORMAT_BIT] = s.format_right;
        control_byte[`ADC_CTL_CLOCK_MSB:`ADC_CTL_CLOCK_LSB] = s.clock_sel;
        control_byte[`ADC_CTL_NEG_REF_BIT] = s.neg_ref;
        control_byte[`ADC_CTL_POS_REF_MSB:`ADC_CTL_POS_REF_LSB] = s.pos_ref;
    endfunction : control_byte

    function automatic logic [31:0] status_word(input regs_state_type s);
        status_word = 32'h0000_0000;
        status_word[`ADC_STS_FRESH_BIT] = s.result_fresh;
        status_word[`ADC_STS_POS_RSVD_BIT] =
            (s.pos_ref == `ADC_POS_REF_RESERVED);
        status_word[`ADC_STS_COUNT_MSB:`ADC_STS_COUNT_LSB] = s.done_count;
    endfunction : status_word

    assign link.format_right = s_q.format_right;
    assign link.value = CONV_VALUE_IN;
    assign link.clock_sel = s_q.clock_sel;

    adc_result_formatter u_formatter (
        .link(link.formatter)
    );

    adc_conv_clock u_conv_clock (
        .clk_in(CORE_CLK_IN),
        .reset_in(RESET_IN),
        .rc_osc_in(RC_OSC_IN),
        .link(link.ticker)
    );

    assign control_reset = `ADC_CONTROL_RESET;
    assign sel = decode(PADDR_IN);
    assign setup_phase = PSEL_IN & ~PENABLE_IN;
    assign write_done = PSEL_IN & PENABLE_IN & PWRITE_IN;

    always_comb begin
        s_d = s_q;
        if (RESET_IN) begin
            // Results keep their contents; everything else returns to reset.
            s_d.format_right = control_reset[`ADC_CTL_FORMAT_BIT];
            s_d.clock_sel = control_reset[`ADC_CTL_CLOCK_MSB:
                `ADC_CTL_CLOCK_LSB];
            s_d.neg_ref = control_reset[`ADC_CTL_NEG_REF_BIT];
            s_d.pos_ref = control_reset[`ADC_CTL_POS_REF_MSB:
                `ADC_CTL_POS_REF_LSB];
            s_d.result_fresh = 1'b0;
            s_d.done_count = `ADC_COUNT_RESET;
            s_d.rdata = `ADC_RDATA_RESET;
            s_d.slverr = 1'b0;
        end else begin
            // Read data and the error answer are captured in the setup cycle.
            if (setup_phase) begin
                s_d.slverr = (sel == SEL_NONE);
                case (sel)
                    SEL_CONTROL: s_d.rdata = {24'h000000, control_byte(s_q)};
                    SEL_RESULT_HIGH: s_d.rdata = {24'h000000, s_q.res_high};
                    SEL_RESULT_LOW: s_d.rdata = {24'h000000, s_q.res_low};
                    SEL_STATUS: s_d.rdata = status_word(s_q);
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
            if (write_done) begin
                case (sel)
                    SEL_CONTROL: begin
                        s_d.format_right = PWDATA_IN[`ADC_CTL_FORMAT_BIT];
                        s_d.clock_sel = PWDATA_IN[`ADC_CTL_CLOCK_MSB:
                            `ADC_CTL_CLOCK_LSB];
                        s_d.neg_ref = PWDATA_IN[`ADC_CTL_NEG_REF_BIT];
                        s_d.pos_ref = PWDATA_IN[`ADC_CTL_POS_REF_MSB:
                            `ADC_CTL_POS_REF_LSB];
                    end
                    SEL_RESULT_HIGH: s_d.res_high = PWDATA_IN[7:0];
                    SEL_RESULT_LOW: s_d.res_low = PWDATA_IN[7:0];
                    SEL_STATUS: begin
                        if (PWDATA_IN[`ADC_STS_FRESH_BIT]) begin
                            s_d.result_fresh = 1'b0;
                        end
                    end
                    default: s_d.result_fresh = s_q.result_fresh;
                endcase
            end
            // A completion beats a software write or clear in the same cycle.
            if (CONV_DONE_IN) begin
                s_d.res_high = link.high_byte;
                s_d.res_low = link.low_byte;
                s_d.result_fresh = 1'b1;
                s_d.done_count = s_q.done_count + 8'h01;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        s_q <= s_d;
    end

    assign PRDATA_OUT = s_q.rdata;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & s_q.slverr;
    assign CONV_TICK_OUT = link.tick;
    assign CONV_CLOCK_SELECT_OUT = s_q.clock_sel;
    assign RC_CLOCK_SELECTED_OUT = (s_q.clock_sel == CLK_RC_OSC) ||
        (s_q.clock_sel == CLK_RC_OSC_ALT);
    assign POS_REF_SELECT_OUT = s_q.pos_ref;
    assign NEG_REF_SELECT_OUT = s_q.neg_ref;
    assign FORMAT_RIGHT_OUT = s_q.format_right;

endmodule : adc_config_and_result_regs

// >>> design/adc_conv_clock.sv
`timescale 1ns/1ps
`include "adc_regs_map.svh"
module adc_conv_clock
    import adc_regs_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Dedicated RC oscillator, asynchronous to the system clock.
    input wire logic rc_osc_in,
    // Select in, tick out.
    adc_link_if.ticker link
);

    ticker_state_type s_q;
    ticker_state_type s_d;

    function automatic logic [6:0] div_limit(input logic [2:0] sel);
        case (sel)
            CLK_SYS_DIV2: div_limit = `ADC_DIV_CODE0;
            CLK_SYS_DIV8: div_limit = `ADC_DIV_CODE1;
            CLK_SYS_DIV32: div_limit = `ADC_DIV_CODE2;
            CLK_SYS_DIV4: div_limit = `ADC_DIV_CODE4;
            CLK_SYS_DIV16: div_limit = `ADC_DIV_CODE5;
            CLK_SYS_DIV64: div_limit = `ADC_DIV_CODE6;
            default: div_limit = `ADC_DIV_CODE0;
        endcase
    endfunction : div_limit

    function automatic logic is_rc(input logic [2:0] sel);
        is_rc = (sel == CLK_RC_OSC) || (sel == CLK_RC_OSC_ALT);
    endfunction : is_rc

    always_comb begin
        s_d = s_q;
        s_d.rc_sync1 = rc_osc_in;
        s_d.rc_sync2 = s_q.rc_sync1;
        s_d.rc_prev = s_q.rc_sync2;
        s_d.tick = 1'b0;
        if (reset_in) begin
            s_d.div_cnt = 7'h00;
            s_d.rc_prev = 1'b0;
        end else if (is_rc(link.clock_sel)) begin
            // Tick once per rising edge of the synchronised oscillator.
            s_d.div_cnt = 7'h00;
            s_d.tick = s_q.rc_sync2 & ~s_q.rc_prev;
        end else if (s_q.div_cnt >= div_limit(link.clock_sel) - 7'h01) begin
            s_d.div_cnt = 7'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        s_q <= s_d;
    end

    assign link.tick = s_q.tick;

endmodule : adc_conv_clock

// >>> design/adc_result_formatter.sv
`timescale 1ns/1ps
module adc_result_formatter
    import adc_regs_pkg::*;
(
    adc_link_if.formatter link
);

    always_comb begin
        if (link.format_right) begin
            link.high_byte = {6'h00, link.value[9:8]};
            link.low_byte = link.value[7:0];
        end else begin
            link.high_byte = link.value[9:2];
            link.low_byte = {link.value[1:0], 6'h00};
        end
    end

endmodule : adc_result_formatter

// >>> verification/adc_config_and_result_regs_bench.sv
`timescale 1ns/1ps
module adc_config_and_result_regs_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic done = 1'b0;
    logic [9:0] value = 10'h000;
    logic rc = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, perr, fmt, rcsel, er;
    logic [2:0] csel;
    logic [9:0] v;
    logic tick, nref;
    logic [1:0] pref;
    int k;
    // Ticks in 64 cycles per divided select code; RC codes are counted apart.
    int exp_ticks [8] = '{32, 8, 2, 0, 16, 4, 1, 0};
    int n_errors = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    always #7 rc = ~rc;
    adc_config_and_result_regs DUT (
        .CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(perr), .CONV_DONE_IN(done), .CONV_VALUE_IN(value),
        .RC_OSC_IN(rc), .CONV_TICK_OUT(tick), .CONV_CLOCK_SELECT_OUT(csel),
        .RC_CLOCK_SELECTED_OUT(rcsel), .POS_REF_SELECT_OUT(pref),
        .NEG_REF_SELECT_OUT(nref), .FORMAT_RIGHT_OUT(fmt)
    );
    task give_verdict;
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (i == 20) begin
            n_errors++;
            give_verdict();
        end
    endtask : apb
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    task convert(input logic [9:0] x);
        @(posedge clk);
        done <= 1'b1;
        value <= x;
        @(posedge clk);
        done <= 1'b0;
    endtask : convert
    task count_ticks(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge clk);
            if (tick === 1'b1) cnt++;
        end
    endtask : count_ticks
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(12'h000, 32'h0);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 12'h000, {24'h0, c[0], c[2:0], 4'hD});
            rdchk(12'h000, {24'h0, c[0], c[2:0], 4'h5});
            check({29'h0, csel}, {29'h0, c[2:0]});
            check({31'h0, rcsel}, {31'h0, c[1:0] == 2'h3});
            check({31'h0, fmt}, {31'h0, c[0]});
            check({29'h0, nref, pref}, 32'h5);
            count_ticks(64, k);
            if (c[1:0] == 2'h3) begin
                // The oscillator rises every 14 ns: 18 or 19 rises fit here.
                check({31'h0, k inside {18, 19}}, 32'h1);
            end else begin
                check(k, exp_ticks[c]);
            end
        end
        for (int f = 0; f < 2; f++) begin
            v = f ? 10'h2D6 : 10'h169;
            apb(1'b1, 12'h000, {24'h0, f[0], 7'h00});
            convert(~v);
            convert(v);
            rdchk(12'h004, f ? {30'h0, v[9:8]}
                : {24'h0, v[9:2]});
            rdchk(12'h008, f ? {24'h0, v[7:0]}
                : {24'h0, v[1:0], 6'h00});
        end
        rdchk(12'h00C, 32'h0000_0401);
        apb(1'b1, 12'h00C, 32'h1);
        rdchk(12'h00C, 32'h0000_0400);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(12'h000, 32'h0);
        check({29'h0, nref, pref}, 32'h0);
        rdchk(12'h004, {30'h0, v[9:8]});
        apb(1'b1, 12'h008, 32'hA5);
        rdchk(12'h008, 32'hA5);
        convert(v);
        rdchk(12'h008, {24'h0, v[1:0], 6'h00});
        apb(1'b1, 12'h010, 32'hFF);
        check({31'h0, er}, 32'h1);
        rdchk(12'h000, 32'h0);
        give_verdict();
    end
endmodule : adc_config_and_result_regs_bench

// >>> verification/adc_regs_asserts.sv
`timescale 1ns/1ps
module adc_regs_asserts (
    // Clock, reset and bus.
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    // Converter and configuration.
    input wire logic CONV_DONE_IN,
    input wire logic [9:0] CONV_VALUE_IN,
    input wire logic [2:0] CONV_CLOCK_SELECT_OUT,
    input wire logic RC_CLOCK_SELECTED_OUT,
    input wire logic FORMAT_RIGHT_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);
    logic acc, wr_ctl, rd_hi, rd_lo, wfmt, ok_q, fmt_q;
    logic [2:0] wclk;
    logic [9:0] val_q;
    assign acc = PSEL_IN && PENABLE_IN;
    assign wr_ctl = acc && PWRITE_IN && PADDR_IN == 12'h000;
    assign rd_hi = PSEL_IN && !PENABLE_IN && !PWRITE_IN && !CONV_DONE_IN
        && PADDR_IN == 12'h004;
    assign rd_lo = PSEL_IN && !PENABLE_IN && !PWRITE_IN && !CONV_DONE_IN
        && PADDR_IN == 12'h008;
    assign wfmt = PWDATA_IN[7];
    assign wclk = PWDATA_IN[6:4];
    // Remembers the last completion until software overwrites a result.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            ok_q <= 1'b0;
        end else if (CONV_DONE_IN) begin
            ok_q <= 1'b1;
            val_q <= CONV_VALUE_IN;
            fmt_q <= FORMAT_RIGHT_OUT;
        end else if (acc && PWRITE_IN
            && PADDR_IN inside {12'h004, 12'h008}) begin
            ok_q <= 1'b0;
        end
    end
    property p_high_layout;
        ok_q && rd_hi |=> PRDATA_OUT ==
            (fmt_q ? {30'h0, val_q[9:8]} : {24'h0, val_q[9:2]});
    endproperty
    property p_low_layout;
        ok_q && rd_lo |=> PRDATA_OUT ==
            (fmt_q ? {24'h0, val_q[7:0]} : {24'h0, val_q[1:0], 6'h00});
    endproperty
    property p_fmt_write;
        wr_ctl |=> FORMAT_RIGHT_OUT == $past(wfmt);
    endproperty
    property p_clk_write;
        wr_ctl |=> CONV_CLOCK_SELECT_OUT == $past(wclk);
    endproperty
    property p_fmt_hold;
        $changed(FORMAT_RIGHT_OUT) |-> $past(wr_ctl);
    endproperty
    property p_clk_hold;
        !$stable(CONV_CLOCK_SELECT_OUT) |-> $past(wr_ctl);
    endproperty
    property p_rc_sel;
        RC_CLOCK_SELECTED_OUT == (CONV_CLOCK_SELECT_OUT[1:0] == 2'h3);
    endproperty
    property p_reset_ctl;
        @(posedge CORE_CLK_IN) disable iff (1'b0)
        $fell(RESET_IN) |-> !FORMAT_RIGHT_OUT && CONV_CLOCK_SELECT_OUT == 3'h0;
    endproperty
    a_high_layout: assert property (p_high_layout)
        else $error("high result byte layout wrong");
    a_low_layout: assert property (p_low_layout)
        else $error("low result byte layout wrong");
    a_fmt_write: assert property (p_fmt_write)
        else $error("format bit not written");
    a_clk_write: assert property (p_clk_write)
        else $error("clock select not written");
    a_fmt_hold: assert property (p_fmt_hold)
        else $error("format bit changed without a write");
    a_clk_hold: assert property (p_clk_hold)
        else $error("clock select changed without a write");
    a_rc_sel: assert property (p_rc_sel)
        else $error("RC selection flag wrong");
    a_reset_ctl: assert property (p_reset_ctl)
        else $error("control not cleared by reset");
    c_left: cover property (ok_q && rd_hi && !fmt_q);
    c_right: cover property (ok_q && rd_lo && fmt_q);
    c_ctl: cover property (wr_ctl);
endmodule : adc_regs_asserts

bind adc_config_and_result_regs adc_regs_asserts u_chk (
    .CORE_CLK_IN(CORE_CLK_IN),
    .RESET_IN(RESET_IN),
    .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN),
    .PRDATA_OUT(PRDATA_OUT),
    .CONV_DONE_IN(CONV_DONE_IN),
    .CONV_VALUE_IN(CONV_VALUE_IN),
    .CONV_CLOCK_SELECT_OUT(CONV_CLOCK_SELECT_OUT),
    .RC_CLOCK_SELECTED_OUT(RC_CLOCK_SELECTED_OUT),
    .FORMAT_RIGHT_OUT(FORMAT_RIGHT_OUT)
);
